/* lirc_top.sv */
// module: reset controller with its register port and reset scopes
//
// Functional notes
// - four reset sources: power, pin, global, channel
// - global resets reinitialise common and channel logic
// - channel reset touches only its channel
// - line pins high impedance during reset
// - line mode defaults to T1/J1 after reset
// - system interface defaults to dual-rail NRZ
// - global reset makes data and GPIO inputs
// - state machines return to initial state
// - reset masks affected interrupt sources
// - registers reset; channel keeps line mode
// - power-on ends within 1 ms, needs clock
// - low pin holds the device in reset
// - global register write resets within 1 us
// - channel bit resets within 1 us, self-clears
// - channel reset spares common registers and pins
// - channel reset spares other channels
// - lost master clock powers down, then resets
//
// The plain strobed port and the address map were left to the implementer.
`default_nettype none
module lirc_top (
   input wire logic clk, // internal clock, 50 MHz
   input wire logic rst, // power-on reset, active high
   input wire logic reset_pin_n, // hardware reset pin, active low
   input wire logic mclk_in, // master clock sampled as a level
   input wire logic [lirc_pkg::ADDR_W-1:0] addr, // register address
   input wire logic [lirc_pkg::DATA_W-1:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [lirc_pkg::DATA_W-1:0] rdata, // read data, cycle after rd
   output logic glob_reset, // global reset scope
   output logic [lirc_pkg::NUM_CH-1:0] ch_reset, // per-channel reset scope
   output logic [lirc_pkg::NUM_CH-1:0] line_oe, // line pins drive enable
   output logic [lirc_pkg::NUM_CH-1:0] line_mode, // 0 T1/J1, 1 E1
   output logic [lirc_pkg::NUM_CH-1:0] sys_nrz_dual, // system side dual-rail NRZ
   output logic [lirc_pkg::NUM_CH-1:0] int_mask_all, // all channel sources masked
   output logic [1:0] gpio_dir, // general purpose direction, 1 output
   output logic data_bus_oe, // parallel data bus output enable
   output logic power_down // master clock lost
);
   import lirc_pkg::*;
   lirc_ch_if chif ();
   // ---------------------------------------------------------------
   // pin synchronisers: three stages, change taken when 2 and 3 agree
   // ---------------------------------------------------------------
   logic [2:0] pin_sync_q, pin_sync_d;
   logic [2:0] mck_sync_q, mck_sync_d;
   logic pin_low_q, pin_low_d;
   logic mck_lvl_q, mck_lvl_d;
   always_comb begin
      pin_sync_d = {pin_sync_q[1:0], reset_pin_n};
      mck_sync_d = {mck_sync_q[1:0], mclk_in};
      pin_low_d = pin_low_q;
      mck_lvl_d = mck_lvl_q;
      if (pin_sync_q[1] == pin_sync_q[2]) begin
         pin_low_d = ~pin_sync_q[2];
      end
      if (mck_sync_q[1] == mck_sync_q[2]) begin
         mck_lvl_d = mck_sync_q[2];
      end
      if (rst) begin
         pin_low_d = 1'b0;
         mck_lvl_d = 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      pin_sync_q <= pin_sync_d;
      mck_sync_q <= mck_sync_d;
      pin_low_q <= pin_low_d;
      mck_lvl_q <= mck_lvl_d;
   end
   // ---------------------------------------------------------------
   // master clock watch: high/low sample counts over a 10 us window
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] win_q, win_d, hi_q, hi_d;
   logic mck_prev_q, mck_prev_d;
   logic mck_seen_q, mck_seen_d;
   logic mck_lost_q, mck_lost_d;
   always_comb begin
      win_d = win_q + CNT_W'(1);
      hi_d = hi_q + CNT_W'(mck_lvl_q);
      mck_prev_d = mck_lvl_q;
      mck_seen_d = mck_seen_q | (mck_lvl_q != mck_prev_q);
      mck_lost_d = mck_lost_q;
      if (win_q == CNT_W'(LOSS_CYC - 1)) begin
         // duty below the limit on either phase means the clock is gone
         mck_lost_d = ~mck_seen_d
            || (hi_d < CNT_W'(LOSS_CYC * DUTY_PCT / 100))
            || (hi_d > CNT_W'(LOSS_CYC * (100 - DUTY_PCT) / 100));
         win_d = '0;
         hi_d = '0;
         mck_seen_d = 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         win_q <= '0;
         hi_q <= '0;
         mck_prev_q <= 1'b0;
         mck_seen_q <= 1'b0;
         mck_lost_q <= 1'b1; // assume no clock until one is proven
      end else begin
         win_q <= win_d;
         hi_q <= hi_d;
         mck_prev_q <= mck_prev_d;
         mck_seen_q <= mck_seen_d;
         mck_lost_q <= mck_lost_d;
      end
   end
   // ---------------------------------------------------------------
   // global sequencer: hold, run, powered down
   // ---------------------------------------------------------------
   lirc_state_t st_q, st_d;
   logic [CNT_W-1:0] gcnt_q, gcnt_d;
   logic grst_wr;
   logic greset_d;
   assign grst_wr = wr && (addr == ADDR_GRST);
   always_comb begin
      st_d = st_q;
      gcnt_d = gcnt_q;
      unique case (st_q)
         LIRC_ST_HOLD: begin
            // stays here without a master clock or while pin is low
            if (pin_low_q || mck_lost_q) begin
               gcnt_d = CNT_W'(SWRST_CYC - 1);
            end else if (gcnt_q == '0) begin
               st_d = LIRC_ST_RUN;
            end else begin
               gcnt_d = gcnt_q - CNT_W'(1);
            end
         end
         LIRC_ST_RUN: begin
            if (mck_lost_q) begin
               st_d = LIRC_ST_DOWN;
            end else if (pin_low_q || grst_wr) begin
               st_d = LIRC_ST_HOLD;
               gcnt_d = CNT_W'(SWRST_CYC - 1);
            end
         end
         LIRC_ST_DOWN: begin
            if (!mck_lost_q) begin
               st_d = LIRC_ST_HOLD;
               gcnt_d = CNT_W'(SWRST_CYC - 1);
            end
         end
         default: st_d = LIRC_ST_HOLD;
      endcase
      greset_d = (st_d != LIRC_ST_RUN);
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= LIRC_ST_HOLD;
         gcnt_q <= CNT_W'(SWRST_CYC - 1);
      end else begin
         st_q <= st_d;
         gcnt_q <= gcnt_d;
      end
   end
   // ---------------------------------------------------------------
   // channel reset requests go to the timer module
   // ---------------------------------------------------------------
   logic [NUM_CH-1:0] ch_start;
   logic glob_q;
   logic [ADDR_W-CH_LSB-1:0] wr_ch;
   logic [CH_LSB-1:0] wr_low;
   assign wr_ch = addr[ADDR_W-1:CH_LSB];
   assign wr_low = addr[CH_LSB-1:0];
   always_comb begin
      ch_start = '0;
      if (wr && wr_low == ADDR_CHANNEL_CONFIG_REGISTER[CH_LSB-1:0] && wdata[BIT_CHANNEL_RESET_BIT]
          && 32'(wr_ch) < NUM_CH) begin
         ch_start[wr_ch[3:0]] = 1'b1;
      end
   end
   assign chif.start = ch_start & ~{NUM_CH{glob_q}};
   lirc_ch_timer u_timer (
      .clk(clk),
      .glob_rst(glob_q),
      .chif(chif)
   );
   // ---------------------------------------------------------------
   // channel registers: mode kept by channel reset, others default
   // ---------------------------------------------------------------
   logic [NUM_CH-1:0] mode_q, mode_d;
   logic [DATA_W-1:0] intm_q [NUM_CH];
   logic [DATA_W-1:0] intm_d [NUM_CH];
   logic [DATA_W-1:0] sysf_q [NUM_CH];
   logic [DATA_W-1:0] sysf_d [NUM_CH];
   logic [NUM_CH-1:0] chr_any;
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_reg
         // a mask or system-side write while the channel is in reset is dropped; mode writes still land unless a global reset is on
         logic sel;
         assign sel = wr && 32'(wr_ch) == g;
         assign chr_any[g] = glob_q | chif.busy[g] | ch_start[g];
         always_comb begin
            mode_d[g] = mode_q[g];
            intm_d[g] = intm_q[g];
            sysf_d[g] = sysf_q[g];
            if (glob_q) begin
               mode_d[g] = MODE_T1;
            end else if (sel && wr_low == ADDR_CHANNEL_CONFIG_REGISTER[CH_LSB-1:0]) begin
               mode_d[g] = wdata[BIT_MODE];
            end
            if (chr_any[g]) begin
               intm_d[g] = INTM_RST;
               sysf_d[g] = SYSF_RST;
            end else if (sel && wr_low == ADDR_INTM0[CH_LSB-1:0]) begin
               intm_d[g] = wdata;
            end else if (sel && wr_low == ADDR_SYSF[CH_LSB-1:0]) begin
               sysf_d[g] = wdata;
            end
         end
         always_ff @(posedge clk) begin
            mode_q[g] <= mode_d[g];
            intm_q[g] <= intm_d[g];
            sysf_q[g] <= sysf_d[g];
         end
      end
   endgenerate
   // ---------------------------------------------------------------
   // common registers: touched only by a global reset
   // ---------------------------------------------------------------
   logic [3:0] gpio_q, gpio_d;
   always_comb begin
      gpio_d = gpio_q;
      if (glob_q) begin
         gpio_d = GPIO_RST;
      end else if (wr && addr == ADDR_GPIO) begin
         gpio_d = wdata[3:0];
      end
   end
   always_ff @(posedge clk) begin
      gpio_q <= gpio_d;
   end
   // ---------------------------------------------------------------
   // read port: data in the cycle after the strobe
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] rdata_d;
   always_comb begin
      rdata_d = '0;
      if (rd && !rst) begin
         if (addr == ADDR_ID) begin
            rdata_d = ID_VALUE;
         end else if (addr == ADDR_GPIO) begin
            rdata_d = {4'h0, gpio_q};
         end else if (addr == ADDR_STAT) begin
            rdata_d = {5'h00, st_q, mck_lost_q};
         end else if (32'(wr_ch) < NUM_CH) begin
            if (wr_low == ADDR_CHANNEL_CONFIG_REGISTER[CH_LSB-1:0]) begin
               rdata_d = {6'h00, chif.busy[wr_ch[3:0]], mode_q[wr_ch[3:0]]};
            end else if (wr_low == ADDR_INTM0[CH_LSB-1:0]) begin
               rdata_d = intm_q[wr_ch[3:0]];
            end else if (wr_low == ADDR_SYSF[CH_LSB-1:0]) begin
               rdata_d = sysf_q[wr_ch[3:0]];
            end
         end
      end
   end
   // ---------------------------------------------------------------
   // output next values; every reset scope is applied through these
   // ---------------------------------------------------------------
   logic glob_reset_d;
   logic [NUM_CH-1:0] ch_reset_d, line_oe_d, line_mode_d, sys_nrz_dual_d, int_mask_all_d;
   logic [1:0] gpio_dir_d;
   logic data_bus_oe_d;
   logic power_down_d;
   always_comb begin
      glob_reset_d = greset_d;
      // scope follows the sequencer directly, so it ends with the global reset
      ch_reset_d = chif.busy | chif.start | {NUM_CH{greset_d}};
      line_oe_d = ~ch_reset_d;
      line_mode_d = mode_d;
      for (int i = 0; i < NUM_CH; i++) begin
         sys_nrz_dual_d[i] = (sysf_d[i] == SYSF_RST);
         int_mask_all_d[i] = (intm_d[i] == INTM_RST);
      end
      gpio_dir_d = gpio_d[1:0];
      data_bus_oe_d = rd && !greset_d;
      power_down_d = (st_d == LIRC_ST_DOWN);
      // power-on reset forces every output to its safe level at once
      if (rst) begin
         glob_reset_d = 1'b1;
         ch_reset_d = '1;
         line_oe_d = '0;
         line_mode_d = {NUM_CH{MODE_T1}};
         sys_nrz_dual_d = '1;
         int_mask_all_d = '1;
         gpio_dir_d = GPIO_RST[1:0];
         data_bus_oe_d = 1'b0;
         power_down_d = 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      rdata <= rdata_d;
      glob_q <= glob_reset_d;
      glob_reset <= glob_reset_d;
      ch_reset <= ch_reset_d;
      line_oe <= line_oe_d;
      line_mode <= line_mode_d;
      sys_nrz_dual <= sys_nrz_dual_d;
      int_mask_all <= int_mask_all_d;
      gpio_dir <= gpio_dir_d;
      data_bus_oe <= data_bus_oe_d;
      power_down <= power_down_d;
   end
endmodule : lirc_top
`default_nettype wire

/* lirc_pkg.sv */
// package: constants and types for the line interface reset controller
`default_nettype none
package lirc_pkg;
   localparam int unsigned NUM_CH = 16;
   localparam int unsigned ADDR_W = 11;
   localparam int unsigned DATA_W = 8;
   // register addresses
   localparam logic [10:0] ADDR_ID = 11'h000;
   localparam logic [10:0] ADDR_GRST = 11'h040;
   localparam logic [10:0] ADDR_GPIO = 11'h100;
   localparam logic [10:0] ADDR_CHANNEL_CONFIG_REGISTER = 11'h001;
   localparam logic [10:0] ADDR_INTM0 = 11'h010;
   localparam logic [10:0] ADDR_SYSF = 11'h011;
   localparam logic [10:0] ADDR_STAT = 11'h7c0;
   localparam logic [5:0] CH_SHIFT = 6'h06;
   localparam int unsigned CH_LSB = 6;
   localparam logic [5:0] CH_LOW_MASK = 6'h3f;
   // field positions
   localparam int unsigned BIT_MODE = 0;
   localparam int unsigned BIT_CHANNEL_RESET_BIT = 1;
   // reset values
   localparam logic [7:0] ID_VALUE = 8'h5a; // arbitrary identity value
   localparam logic [7:0] INTM_RST = 8'hff;
   localparam logic [7:0] SYSF_RST = 8'h00;
   localparam logic [3:0] GPIO_RST = 4'h0;
   localparam logic MODE_T1 = 1'b0;
   // timing
   localparam int unsigned CLK_MHZ = 50;
   localparam int unsigned CLK_NS = 20;
   localparam int unsigned POR_US = 1000;
   localparam int unsigned POR_CYC = POR_US * CLK_MHZ;
   localparam int unsigned SWRST_NS = 1000;
   localparam int unsigned SWRST_CYC = SWRST_NS / CLK_NS;
   localparam int unsigned LOSS_US = 10;
   localparam int unsigned LOSS_CYC = LOSS_US * CLK_MHZ;
   localparam int unsigned DUTY_PCT = 30;
   localparam int unsigned CNT_W = 16;
   typedef enum logic [1:0] {
      LIRC_ST_HOLD = 2'b00,
      LIRC_ST_RUN = 2'b01,
      LIRC_ST_DOWN = 2'b11
   } lirc_state_t;
endpackage : lirc_pkg
`default_nettype wire

/* lirc_ch_if.sv */
// interface: per-channel reset requests and timer status
`default_nettype none
interface lirc_ch_if;
   import lirc_pkg::*;
   logic [NUM_CH-1:0] start;
   logic [NUM_CH-1:0] busy;
   modport ctrl (output start, input busy);
   modport timer (input start, output busy);
endinterface : lirc_ch_if
`default_nettype wire

/* lirc_ch_timer.sv */
// module: per-channel software reset timers
`default_nettype none
module lirc_ch_timer (
   input wire logic clk, // internal clock
   input wire logic glob_rst, // global reset scope
   lirc_ch_if.timer chif // start and busy per channel
);
   import lirc_pkg::*;
   logic [CNT_W-1:0] cnt_q [NUM_CH];
   logic [CNT_W-1:0] cnt_d [NUM_CH];
   logic [NUM_CH-1:0] busy_q;
   logic [NUM_CH-1:0] busy_d;
   genvar g;
   // ---------------------------------------------------------------
   // one down counter per channel; each runs only for its own channel
   // ---------------------------------------------------------------
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         always_comb begin
            cnt_d[g] = cnt_q[g];
            busy_d[g] = busy_q[g];
            if (glob_rst) begin
               cnt_d[g] = '0;
               busy_d[g] = 1'b0;
            end else if (chif.start[g]) begin
               // the write cycle already counts, so one less keeps it within 1 us
               cnt_d[g] = CNT_W'(SWRST_CYC - 2);
               busy_d[g] = 1'b1;
            end else if (busy_q[g]) begin
               if (cnt_q[g] == '0) begin
                  busy_d[g] = 1'b0;
               end else begin
                  cnt_d[g] = cnt_q[g] - CNT_W'(1);
               end
            end
         end
         always_ff @(posedge clk) begin
            cnt_q[g] <= cnt_d[g];
            busy_q[g] <= busy_d[g];
         end
      end
   endgenerate
   assign chif.busy = busy_q;
endmodule : lirc_ch_timer
`default_nettype wire

/* lirc_chk.sv */
// checker: reset scope assertions on the controller's ports
`default_nettype none
module lirc_chk (
   input wire logic clk, // internal clock
   input wire logic rst, // power-on reset
   input wire logic reset_pin_n, // reset pin, active low
   input wire logic [lirc_pkg::ADDR_W-1:0] addr, // register address
   input wire logic [lirc_pkg::DATA_W-1:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic glob_reset, // global scope
   input wire logic [lirc_pkg::NUM_CH-1:0] ch_reset, // channel scope
   input wire logic [lirc_pkg::NUM_CH-1:0] line_oe, // line drive enable
   input wire logic [lirc_pkg::NUM_CH-1:0] line_mode, // line mode
   input wire logic [lirc_pkg::NUM_CH-1:0] sys_nrz_dual, // dual-rail nrz
   input wire logic [lirc_pkg::NUM_CH-1:0] int_mask_all, // sources masked
   input wire logic [1:0] gpio_dir // gpio direction
);
   import lirc_pkg::*;
   logic ch_wr;
   logic g_wr;
   logic [3:0] sel_d;
   logic [3:0] sel_q;
   // ----------------------------------------
   // request decode
   // ----------------------------------------
   // writes inside a global reset are dropped, so they never count
   assign ch_wr = wr && !glob_reset && !addr[10] && addr[5:0] == ADDR_CHANNEL_CONFIG_REGISTER[5:0]
      && wdata[BIT_CHANNEL_RESET_BIT];
   assign g_wr = wr && !glob_reset && addr == ADDR_GRST;
   // remember which channel was asked to reset
   always_comb begin
      sel_d = rst ? 4'h0 : (ch_wr ? addr[9:6] : sel_q);
   end
   always_ff @(posedge clk) begin
      sel_q <= sel_d;
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_glob_run;
      glob_reset [*8] ##[30:50] !glob_reset;
   endsequence
   sequence s_ch_run;
      ch_reset[sel_q] [*8] ##[30:50] !ch_reset[sel_q];
   endsequence
   property p_oe_off;
      (line_oe & (ch_reset | {NUM_CH{glob_reset}})) == '0;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("line pins driven during reset");
   property p_glob_all;
      glob_reset |-> ch_reset == '1;
   endproperty
   a_glob_all: assert property (p_glob_all)
      else $error("global reset misses a channel");
   property p_glob_io;
      glob_reset && $past(glob_reset, 2) |-> gpio_dir == 2'b00;
   endproperty
   a_glob_io: assert property (p_glob_io)
      else $error("gpio not input in global reset");
   property p_glob_def;
      glob_reset && $past(glob_reset, 2) |->
         line_mode == '0 && int_mask_all == '1 && sys_nrz_dual == '1;
   endproperty
   a_glob_def: assert property (p_glob_def)
      else $error("defaults missing in global reset");
   property p_gsw;
      g_wr |=> s_glob_run;
   endproperty
   a_gsw: assert property (p_gsw)
      else $error("global software reset timing wrong");
   property p_channel_reset_bit;
      ch_wr |=> s_ch_run;
   endproperty
   a_channel_reset_bit: assert property (p_channel_reset_bit)
      else $error("channel reset timing wrong");
   property p_ch_only;
      !glob_reset && (ch_reset & ~$past(ch_reset)) != '0 |->
         $past(ch_wr) && (ch_reset & ~$past(ch_reset)) == (16'h0001 << $past(addr[9:6]));
   endproperty
   a_ch_only: assert property (p_ch_only)
      else $error("channel reset on wrong channel");
   property p_pin;
      !reset_pin_n [*6] |-> glob_reset;
   endproperty
   a_pin: assert property (p_pin)
      else $error("low reset pin not holding reset");
   property p_rel;
      $fell(glob_reset) |-> reset_pin_n && $past(reset_pin_n, 3);
   endproperty
   a_rel: assert property (p_rel)
      else $error("global reset released with pin low");
endmodule : lirc_chk
bind lirc_top lirc_chk lirc_chk_i (.clk(clk), .rst(rst), .reset_pin_n(reset_pin_n),
   .addr(addr), .wdata(wdata), .wr(wr), .glob_reset(glob_reset), .ch_reset(ch_reset),
   .line_oe(line_oe), .line_mode(line_mode), .sys_nrz_dual(sys_nrz_dual),
   .int_mask_all(int_mask_all), .gpio_dir(gpio_dir));
`default_nettype wire

/* lirc_top_tb.sv */
// testbench: reset sources and scopes against a bench model
`default_nettype none
module lirc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import lirc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic reset_pin_n = 1'b1;
   logic mclk_in = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [10:0] addr = 11'h000;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic glob_reset;
   logic [15:0] ch_reset, line_oe, line_mode, sys_nrz_dual, int_mask_all;
   logic [1:0] gpio_dir;
   logic data_bus_oe, power_down;
   logic [15:0] m_mode, m_mask, m_nrz;
   logic [1:0] m_gpio;
   logic mck_run = 1'b0;
   logic [2:0] mck_cnt = 3'h0;
   int err_count = 0;
   int num_checks = 0;
   lirc_top lirc_top_i (.clk(clk), .rst(rst), .reset_pin_n(reset_pin_n), .mclk_in(mclk_in),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .glob_reset(glob_reset),
      .ch_reset(ch_reset), .line_oe(line_oe), .line_mode(line_mode),
      .sys_nrz_dual(sys_nrz_dual), .int_mask_all(int_mask_all), .gpio_dir(gpio_dir),
      .data_bus_oe(data_bus_oe), .power_down(power_down));
   // ----------------------------------------
   // clocks
   // ----------------------------------------
   initial begin
      forever #10 clk = ~clk;
   end
   // master clock at clk/8; stopping it leaves the line stuck, a real loss
   always @(posedge clk) begin
      if (mck_run) begin
         mck_cnt <= mck_cnt + 3'h1;
         mclk_in <= mck_cnt[2];
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run
   function automatic logic [10:0] ca(int c, logic [10:0] off);
      return 11'(c << CH_LSB) | off;
   endfunction : ca
   task automatic wr_reg(logic [10:0] a, logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(logic [10:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   // wait under a bound for every reset scope to drop, then check it did
   task automatic wait_idle(int lim);
      for (int i = 0; i < lim && (glob_reset !== 1'b0 || ch_reset !== '0); i++) begin
         @(posedge clk);
         #1;
      end
      chk({15'h0, glob_reset} | ch_reset, 16'h0);
   endtask : wait_idle
   task automatic glob_def();
      m_mode = '0;
      m_mask = '1;
      m_nrz = '1;
      m_gpio = 2'b00;
   endtask : glob_def
   task automatic cmp_all();
      chk(line_mode, m_mode);
      chk(sys_nrz_dual, m_nrz);
      chk(int_mask_all, m_mask);
      chk(16'(gpio_dir), 16'(m_gpio));
      chk(line_oe, 16'hffff);
      chk(16'(power_down), 16'h0);
   endtask : cmp_all
   // random contents everywhere, non-default except the mode bit, so resets show their effect
   task automatic scramble();
      logic [7:0] v;
      for (int c = 0; c < NUM_CH; c++) begin
         v = 8'($urandom);
         wr_reg(ca(c, ADDR_CHANNEL_CONFIG_REGISTER), {7'h0, v[0]});
         wr_reg(ca(c, ADDR_INTM0), v & 8'h7f);
         wr_reg(ca(c, ADDR_SYSF), v | 8'h01);
         m_mode[c] = v[0];
         m_mask[c] = 1'b0;
         m_nrz[c] = 1'b0;
      end
      m_gpio = 2'($urandom) | 2'b01;
      wr_reg(ADDR_GPIO, {6'h0, m_gpio});
      wr_reg(11'h7ff, 8'hff);
      repeat (2) @(posedge clk);
      #1 cmp_all();
   endtask : scramble
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      int cs[3];
      logic m;
      logic [7:0] d;
      void'($urandom(98));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (700) @(posedge clk);
      #1 chk(16'(glob_reset), 16'h1);
      chk(line_oe, 16'h0);
      mck_run = 1'b1;
      // a partial window may still read as lost, so allow two windows
      wait_idle(2 * LOSS_CYC + SWRST_CYC + 10);
      glob_def();
      cmp_all();
      scramble();
      cs = '{0, 15, int'($urandom_range(1, 14))};
      foreach (cs[k]) begin
         m = 1'($urandom);
         wr_reg(ca(cs[k], ADDR_CHANNEL_CONFIG_REGISTER), {6'h0, 1'b1, m});
         #1 chk(ch_reset, 16'(32'h1 << cs[k]));
         chk(line_oe, ~16'(32'h1 << cs[k]));
         chk(16'(glob_reset), 16'h0);
         wait_idle(SWRST_CYC);
         m_mode[cs[k]] = m;
         m_mask[cs[k]] = 1'b1;
         m_nrz[cs[k]] = 1'b1;
         @(posedge clk);
         #1 cmp_all();
         rd_reg(ca(cs[k], ADDR_CHANNEL_CONFIG_REGISTER), d);
         chk(16'(d), 16'(m));
         chk(16'(data_bus_oe), 16'h1);
         rd_reg(ca(cs[k], ADDR_INTM0), d);
         chk(16'(d), 16'(INTM_RST));
      end
      scramble();
      wr_reg(ADDR_GRST, 8'($urandom));
      #1 chk(16'(glob_reset), 16'h1);
      chk(ch_reset, 16'hffff);
      wait_idle(SWRST_CYC);
      glob_def();
      @(posedge clk);
      #1 cmp_all();
      scramble();
      @(posedge clk);
      reset_pin_n <= 1'b0;
      // held past 1 us, as the board must for a valid pin reset
      repeat (60) @(posedge clk);
      wr_reg(ADDR_GPIO, 8'h03);
      #1 chk(16'(glob_reset), 16'h1);
      rd_reg(ADDR_GPIO, d);
      chk(16'(data_bus_oe), 16'h0);
      chk(16'(d), 16'(GPIO_RST));
      @(posedge clk);
      reset_pin_n <= 1'b1;
      wait_idle(SWRST_CYC + 10);
      glob_def();
      cmp_all();
      scramble();
      mck_run = 1'b0;
      for (int i = 0; i < 1200 && power_down !== 1'b1; i++) @(posedge clk);
      #1 chk(16'(power_down), 16'h1);
      mck_run = 1'b1;
      // the clock's return ends power down but must start a fresh reset
      for (int i = 0; i < 1200 && power_down !== 1'b0; i++) @(posedge clk);
      #1 chk(16'(glob_reset), 16'h1);
      chk(16'(power_down), 16'h0);
      wait_idle(1200);
      glob_def();
      cmp_all();
      complete_run();
   end
   // watchdog: the whole sequence needs well under this many cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      complete_run();
   end
endmodule : lirc_top_tb
`default_nettype wire
